/* core/lvds_cfg_map.svh */
// Register indices, byte addresses, field positions and reset values.
`ifndef LVDS_CFG_MAP_SVH
`define LVDS_CFG_MAP_SVH

`define LPC_IDX 8'h15
`define L34_IDX 8'h17
`define CTRL_IDX 8'h20
`define STAT_IDX 8'h21
`define LPC_ADDR (`LPC_IDX << 2)
`define L34_ADDR (`L34_IDX << 2)
`define CTRL_ADDR (`CTRL_IDX << 2)
`define STAT_ADDR (`STAT_IDX << 2)

`define REG_RESET 16'h0000
`define CTRL_RESET 1'h0
`define PRNG_BIT_L1 15
`define CODE_LSB_L1 9
`define CODE_LSB_L2 6
`define CODE_LSB_L3 5
`define CODE_LSB_L4 2
`define ROUND_BIT 5
`define K_LSB 1
`define ENABLE_BIT 0
`define SEL_BIT 0
`define STAT_ACTIVE_BIT 8

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define READY_MARGIN 4
`define FRAC_BITS 12

`endif

/* core/lvds_cfg_pkg.sv */
// Types shared by the lane configuration and filter block.
package lvds_cfg_pkg;

    typedef enum logic [2:0] {
        PC_NORMAL = 3'h0,
        PC_SYNC = 3'h1,
        PC_ALTERNATE = 3'h2,
        PC_CUSTOM = 3'h3,
        PC_ONES = 3'h4,
        PC_TOGGLE = 3'h5,
        PC_ZEROS = 3'h6,
        PC_RAMP = 3'h7
    } pattern_code_encoding_type;

    typedef logic [7:0] addr_type;
    typedef logic [31:0] word_type;
    typedef logic [3:0] strb_type;
    typedef logic [1:0] resp_type;
    typedef logic [15:0] reg16_type;

endpackage : lvds_cfg_pkg

/* core/fifo_if.sv */
// Push and pop handshake between the sample pipeline and its FIFO.
`timescale 1ns/1ps
interface fifo_if #(
    parameter int WIDTH = 56,
    parameter int LW = 6
);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic [LW-1:0] level;

    modport user (
        output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data, level
    );
    modport store (
        input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data, level
    );
endinterface : fifo_if

/* core/sample_fifo.sv */
// Sample FIFO with a registered output word.
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 56,
    parameter int DEPTH = 32,
    parameter int LW = 6
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Both sides
    fifo_if.store f
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [LW-1:0] count_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    logic push;
    logic load;

    // Pointers wrap by overflow, so DEPTH must be a power of two.
    assign f.push_ready = (count_q < LW'(DEPTH));
    assign push = f.push_valid && f.push_ready;
    assign load = (count_q != '0) && (!out_valid_q || f.pop_ready);
    assign f.pop_valid = out_valid_q;
    assign f.pop_data = out_data_q;
    assign f.level = LW'(count_q + LW'(out_valid_q));

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_q] <= f.push_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= PW'(wr_q + 1'b1);
            end
            if (load) begin
                rd_q <= PW'(rd_q + 1'b1);
            end
            count_q <= LW'(count_q + LW'(push) - LW'(load));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (load) begin
            out_valid_q <= 1'b1;
            out_data_q <= mem[rd_q];
        end else if (f.pop_ready) begin
            out_valid_q <= 1'b0;
        end
    end

    a_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn)
        count_q <= LW'(DEPTH))
        else $error("FIFO count above depth.");

endmodule : sample_fifo

/* core/lvds_cfg_top.sv */
// Lane pattern selection and channel high-pass filter with AXI4-Lite regs.
// Behaviour
// - Per-lane select on: bits 15..12 enable lane PRNG.
// - Lane codes at 11-9, 8-6, then 7-5, 4-2.
// - Code decodes normal, sync, alternate, custom, ones, ...
// - Rounding bit clear truncates filter output.
// - Rounding bit set rounds filter output.
// - Enabled filter computes high-pass with k at 4-1.
// - Bit 0 enables filter; off after reset.
// - Both registers read back, reset to zero.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lvds_cfg_map.svh"
module lvds_cfg_top #(
    parameter int SW = 14,
    parameter int CH = 4,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire lvds_cfg_pkg::addr_type awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire lvds_cfg_pkg::word_type wdata,
    input wire lvds_cfg_pkg::strb_type wstrb,
    input wire logic wvalid,
    output logic wready,
    output lvds_cfg_pkg::resp_type bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire lvds_cfg_pkg::addr_type araddr,
    input wire logic arvalid,
    output logic arready,
    output lvds_cfg_pkg::word_type rdata,
    output lvds_cfg_pkg::resp_type rresp,
    output logic rvalid,
    input wire logic rready,
    // Converted samples in
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [SW*CH-1:0] s_data,
    // Filtered samples out
    output logic m_valid,
    input wire logic m_ready,
    output logic [SW*CH-1:0] m_data,
    // Lane pattern controls
    output logic [CH-1:0] lane_prng_on,
    output logic [3*CH-1:0] lane_pattern,
    output logic [CH-1:0] lane_normal
);
    import lvds_cfg_pkg::*;

    localparam int W = SW * CH;
    localparam int FRAC = `FRAC_BITS;
    localparam int IW = SW + FRAC + 4;
    localparam int LW = $clog2(FIFO_DEPTH + 2);
    localparam logic signed [IW-1:0] HALF = IW'(1) <<< (FRAC - 1);
    localparam logic signed [IW-1:0] SMAX = IW'((1 << (SW - 1)) - 1);
    localparam logic signed [IW-1:0] SMIN = -IW'(1 << (SW - 1));

    reg16_type lpc_q;
    reg16_type l34_q;
    logic sel_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_got_q, w_got_q;
    addr_type awaddr_q;
    word_type wdata_q;
    strb_type wstrb_q;
    resp_type bresp_q, rresp_q;
    word_type rdata_q;
    logic s_ready_q;
    logic stage_valid_q;
    logic [W-1:0] stage_data_q;
    logic [CH-1:0] prng_q;
    logic [3*CH-1:0] pattern_q;
    logic [CH-1:0] normal_q;
    logic signed [IW-1:0] x_prev_q [CH];
    logic signed [IW-1:0] y_prev_q [CH];
    logic signed [IW-1:0] y_next [CH];
    logic signed [SW-1:0] filt_out [CH];
    logic [2:0] lane_code [CH];
    logic filt_en;
    logic filt_round;
    logic [3:0] filt_k;
    logic accept;
    logic do_write;
    word_type rd_word;
    resp_type rd_resp;

    fifo_if #(.WIDTH(W), .LW(LW)) fq ();

    sample_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH), .LW(LW)) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .f(fq.store)
    );

    assign filt_en = lpc_q[`ENABLE_BIT];
    assign filt_round = lpc_q[`ROUND_BIT];
    assign filt_k = lpc_q[`K_LSB +: 4];
    assign accept = s_valid && s_ready_q;
    assign do_write = aw_got_q && w_got_q && !bvalid_q;

    // Register write path; address and data may arrive in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            aw_got_q <= 1'b0;
            awaddr_q <= '0;
        end else if (awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_got_q <= 1'b1;
            awaddr_q <= awaddr;
        end else if (do_write) begin
            aw_got_q <= 1'b0;
        end else if (bvalid_q && bready) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b1;
            w_got_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_got_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (do_write) begin
            w_got_q <= 1'b0;
        end else if (bvalid_q && bready) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            case (awaddr_q)
                `LPC_ADDR, `L34_ADDR, `CTRL_ADDR, `STAT_ADDR: begin
                    bresp_q <= `RESP_OKAY;
                end
                default: begin
                    bresp_q <= `RESP_SLVERR;
                end
            endcase
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // All sixteen bits of both registers are stored as written.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lpc_q <= `REG_RESET;
            l34_q <= `REG_RESET;
            sel_q <= `CTRL_RESET;
        end else if (do_write) begin
            for (int b = 0; b < 2; b++) begin
                if (wstrb_q[b] && awaddr_q == `LPC_ADDR) begin
                    lpc_q[8*b +: 8] <= wdata_q[8*b +: 8];
                end
                if (wstrb_q[b] && awaddr_q == `L34_ADDR) begin
                    l34_q[8*b +: 8] <= wdata_q[8*b +: 8];
                end
            end
            if (wstrb_q[0] && awaddr_q == `CTRL_ADDR) begin
                sel_q <= wdata_q[`SEL_BIT];
            end
        end
    end

    // Read path answers one cycle after the address is taken.
    always_comb begin
        rd_word = '0;
        rd_resp = `RESP_OKAY;
        case (araddr)
            `LPC_ADDR: begin
                rd_word[15:0] = lpc_q;
            end
            `L34_ADDR: begin
                rd_word[15:0] = l34_q;
            end
            `CTRL_ADDR: begin
                rd_word[`SEL_BIT] = sel_q;
            end
            `STAT_ADDR: begin
                rd_word[LW-1:0] = fq.level;
                rd_word[`STAT_ACTIVE_BIT] = filt_en;
            end
            default: begin
                rd_resp = `RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_resp;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Lane control decode, one lane per loop entry.
    assign lane_code[0] = lpc_q[`CODE_LSB_L1 +: 3];
    assign lane_code[1] = lpc_q[`CODE_LSB_L2 +: 3];
    assign lane_code[2] = l34_q[`CODE_LSB_L3 +: 3];
    assign lane_code[3] = l34_q[`CODE_LSB_L4 +: 3];

    for (genvar i = 0; i < CH; i++) begin : g_lane
        pattern_code_encoding_type code;
        logic prng;
        always_comb begin
            code = PC_NORMAL;
            prng = 1'b0;
            if (sel_q) begin
                code = pattern_code_encoding_type'(lane_code[i]);
                prng = lpc_q[`PRNG_BIT_L1 - i];
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                prng_q[i] <= 1'b0;
                pattern_q[3*i +: 3] <= PC_NORMAL;
                normal_q[i] <= 1'b1;
            end else begin
                prng_q[i] <= prng;
                pattern_q[3*i +: 3] <= code;
                normal_q[i] <= (code == PC_NORMAL) && !prng;
            end
        end
    end

    // The gain 2^k/(2^k+1) is the alternating series in 2^-k; ten terms
    // keep the error far under one output step even for k of two.
    for (genvar c = 0; c < CH; c++) begin : g_ch
        logic signed [IW-1:0] x_ext, w, r;
        always_comb begin
            x_ext = IW'(signed'(s_data[c*SW +: SW]));
            w = ((x_ext - x_prev_q[c]) <<< FRAC) + y_prev_q[c];
            y_next[c] = w;
            for (int j = 1; j < 10; j++) begin
                y_next[c] = y_next[c] + ((j % 2 != 0) ? -(w >>> (j * filt_k))
                                                      : (w >>> (j * filt_k)));
            end
            if (filt_round) begin
                r = (y_next[c] + HALF) >>> FRAC;
            end else begin
                r = y_next[c] >>> FRAC;
            end
            if (r > SMAX) begin
                filt_out[c] = SMAX[SW-1:0];
            end else if (r < SMIN) begin
                filt_out[c] = SMIN[SW-1:0];
            end else begin
                filt_out[c] = r[SW-1:0];
            end
        end
        // The output history is cleared by each sample accepted while off so that enabling starts clean.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                x_prev_q[c] <= '0;
                y_prev_q[c] <= '0;
            end else if (accept) begin
                x_prev_q[c] <= x_ext;
                y_prev_q[c] <= filt_en ? y_next[c] : '0;
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stage_data_q[c*SW +: SW] <= '0;
            end else if (accept) begin
                stage_data_q[c*SW +: SW] <= filt_en ? filt_out[c]
                                                    : x_ext[SW-1:0];
            end
        end
    end

    // Ready is registered, so it stops early enough to cover one sample
    // in the stage and one taken while the level is still stale.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ready_q <= 1'b0;
            stage_valid_q <= 1'b0;
        end else begin
            s_ready_q <= fq.level <= LW'(FIFO_DEPTH - `READY_MARGIN);
            stage_valid_q <= accept;
        end
    end

    assign fq.push_valid = stage_valid_q;
    assign fq.push_data = stage_data_q;
    assign fq.pop_ready = m_ready;

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign s_ready = s_ready_q;
    assign m_valid = fq.pop_valid;
    assign m_data = fq.pop_data;
    assign lane_prng_on = prng_q;
    assign lane_pattern = pattern_q;
    assign lane_normal = normal_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_prng_lane: assert property (
        lane_prng_on[0] == $past(sel_q && lpc_q[15])
        && lane_prng_on[3] == $past(sel_q && lpc_q[12]))
        else $error("Lane PRNG enable does not follow its bit.");
    a_code_lane: assert property (
        $past(sel_q) |-> lane_pattern[2:0] == $past(lpc_q[11:9])
        && lane_pattern[5:3] == $past(lpc_q[8:6])
        && lane_pattern[8:6] == $past(l34_q[7:5])
        && lane_pattern[11:9] == $past(l34_q[4:2]))
        else $error("Lane pattern code taken from wrong bits.");
    a_normal_decode: assert property (
        lane_normal[1] == (lane_pattern[5:3] == 3'h0 && !lane_prng_on[1]))
        else $error("Normal data flag disagrees with pattern code.");
    a_trunc_floor: assert property (
        accept && filt_en && !filt_round && y_next[0] >= 0
        && y_next[0] < (SMAX <<< FRAC) |=>
        stage_data_q[SW-1:0] == $past(y_next[0][FRAC +: SW]))
        else $error("Truncated output is not the floor.");
    a_round_up: assert property (
        accept && filt_en && filt_round && y_next[0] >= 0
        && y_next[0] < (SMAX <<< FRAC) |=>
        stage_data_q[SW-1:0] == $past(y_next[0][FRAC +: SW]
        + SW'(y_next[0][FRAC-1])))
        else $error("Rounded output does not round half up.");
    a_flat_zero: assert property (
        accept && filt_en && y_prev_q[1] == 0
        && IW'(signed'(s_data[SW +: SW])) == x_prev_q[1]
        ##1 stage_valid_q |-> stage_data_q[SW +: SW] == '0)
        else $error("Flat input with empty history gave nonzero output.");
    a_bypass_pass: assert property (
        accept && !filt_en |=> stage_data_q == $past(s_data)
        && y_prev_q[2] == 0)
        else $error("Disabled filter altered the samples.");
    a_reset_zero: assert property (
        $past(!aresetn) |-> lpc_q == 16'h0000 && l34_q == 16'h0000
        && !sel_q)
        else $error("Registers not zero after reset.");
    a_ignore_sel: assert property (
        !$past(sel_q) |-> lane_prng_on == '0 && lane_pattern == '0
        && lane_normal == '1)
        else $error("Lane controls active without per-lane select.");
    a_no_overflow: assert property (
        fq.push_valid |-> fq.push_ready)
        else $error("Sample pushed into a full FIFO.");

endmodule : lvds_cfg_top

/* verification/sample_sink.sv */
// Downstream receiver model that takes filtered samples with random stalls.
`timescale 1ns/1ps
module sample_sink (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Sample stream from the block
    input wire logic m_valid,
    output logic m_ready = 1'b0,
    // Stall request from the bench
    input wire logic hold
);
    logic [31:0] state_q = 32'h1234ABCD;

    function automatic logic [31:0] step(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : step

    // A real receiver may stall at any cycle, so ready is dropped a quarter
    // of the time whether or not a word is offered.
    always @(posedge aclk) begin
        state_q <= step(state_q);
        m_ready <= aresetn && !hold && (state_q[1:0] != 2'h0);
    end
endmodule : sample_sink

/* verification/tb_lvds_cfg_top.sv */
// Testbench for the lane configuration and channel filter block.
`timescale 1ns/1ps
`include "lvds_cfg_map.svh"
module tb_lvds_cfg_top;
    import lvds_cfg_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    addr_type awaddr = 8'h00, araddr = 8'h00;
    word_type wdata = 32'h0, rdata;
    strb_type wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, s_valid = 1'b0, hold = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, s_ready, m_valid, m_ready;
    resp_type bresp, rresp;
    logic [55:0] s_data = 56'h0, m_data, d;
    logic [3:0] lane_prng_on, lane_normal, pr, nm;
    logic [11:0] lane_pattern;
    logic [2:0] c1, c2, c3, c4;
    logic [31:0] seed = 32'h00003D0B;
    logic [31:0] p;
    logic [55:0] exp_q[$];
    int tol_q[$];
    int num_errors = 0, n_compared = 0;
    real cf;

    always #12.5 aclk = ~aclk;

    lvds_cfg_top #(.SW(14), .CH(4), .FIFO_DEPTH(32)) lvds_cfg_top_inst (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .s_valid, .s_ready,
        .s_data, .m_valid, .m_ready, .m_data, .lane_prng_on,
        .lane_pattern, .lane_normal
    );
    sample_sink sample_sink_inst (.aclk, .aresetn, .m_valid, .m_ready,
        .hold);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic int rq(input real v);
        return int'($floor(v + 0.5));
    endfunction : rq

    function automatic logic [55:0] pack(input int a, b, c, e);
        return {e[13:0], c[13:0], b[13:0], a[13:0]};
    endfunction : pack

    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic tmo(input string what);
        num_errors++;
        $display("wrong value %s expected done seen timeout", what);
        give_verdict();
    endtask : tmo

    task automatic check_word(input string nm_s, input logic [31:0] e, s);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm_s, e, s);
        end
    endtask : check_word

    task automatic check_sample(input logic [55:0] e, s, input int tol);
        int df;
        logic bad;
        bad = (^s === 1'bx);
        n_compared++;
        for (int c = 0; c < 4; c++) begin
            df = int'($signed(s[14*c+:14])) - int'($signed(e[14*c+:14]));
            if (df > tol || df < -tol)
                bad = 1'b1;
        end
        if (bad) begin
            num_errors++;
            $display("wrong value m_data expected %h seen %h", e, s);
        end
    endtask : check_sample

    task automatic axi_write(input addr_type a, input word_type wd,
        input strb_type s, input resp_type er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= wd;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        if (n == 50)
            tmo("bvalid");
        check_word("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input addr_type a, input word_type e,
        input resp_type er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        if (n == 50)
            tmo("rvalid");
        check_word("rdata", e, rdata);
        check_word("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask : axi_read

    task automatic send(input logic [55:0] sd, e, input int tol);
        int n;
        @(posedge aclk);
        s_valid <= 1'b1;
        s_data <= sd;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_ready === 1'b1)
                break;
        end
        if (n == 100)
            tmo("s_ready");
        exp_q.push_back(e);
        tol_q.push_back(tol);
        s_valid <= 1'b0;
    endtask : send

    // The filter keeps a fixed point history, so one count of slack is
    // allowed against the ideal real-valued response.
    task automatic fsend(input real g);
        send(pack(4000, -4000, 1000, -1000), pack(rq(g * 4000),
            rq(-g * 4000), rq(g * 1000), rq(-g * 1000)), 1);
    endtask : fsend

    task automatic drain();
        for (int n = 0; n < 400; n++) begin
            @(posedge aclk);
            if (exp_q.size() == 0)
                return;
        end
        tmo("drain");
    endtask : drain

    always @(posedge aclk) begin
        if (aresetn && m_valid === 1'b1 && m_ready) begin
            if (exp_q.size() == 0)
                check_word("m_valid", 32'h0, 32'h1);
            else
                check_sample(exp_q.pop_front(), m_data, tol_q.pop_front());
        end
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`LPC_ADDR, 32'h0, `RESP_OKAY);
        axi_read(`L34_ADDR, 32'h0, `RESP_OKAY);
        axi_read(`STAT_ADDR, 32'h0, `RESP_OKAY);
        check_word("lanes", 20'h0000F, {lane_prng_on, lane_pattern,
            lane_normal});
        axi_write(8'h10, 32'h1234, 4'hF, `RESP_SLVERR);
        axi_read(8'h10, 32'h0, `RESP_SLVERR);
        axi_write(`LPC_ADDR, 32'hF7E4, 4'h3, `RESP_OKAY);
        axi_write(`LPC_ADDR, 32'h0, 4'h2, `RESP_OKAY);
        axi_read(`LPC_ADDR, 32'hE4, `RESP_OKAY);
        axi_write(`CTRL_ADDR, 32'h1, 4'h1, `RESP_OKAY);
        for (int c = 0; c < 8; c++) begin
            p = rnd() & 32'hF000;
            c1 = c[2:0];
            c2 = ~c1;
            c3 = c1;
            c4 = c1 + 3'h3;
            pr = {p[12], p[13], p[14], p[15]};
            nm = {c4 == 0 && !pr[3], c3 == 0 && !pr[2],
                c2 == 0 && !pr[1], c1 == 0 && !pr[0]};
            p = p | (c1 << 9) | (c2 << 6);
            axi_write(`LPC_ADDR, p, 4'h3, `RESP_OKAY);
            axi_write(`L34_ADDR, (c3 << 5) | (c4 << 2), 4'h3,
                `RESP_OKAY);
            repeat (3) @(posedge aclk);
            check_word("lanes", {pr, c4, c3, c2, c1, nm}, {lane_prng_on,
                lane_pattern, lane_normal});
            axi_read(`LPC_ADDR, p, `RESP_OKAY);
            axi_read(`L34_ADDR, (c3 << 5) | (c4 << 2), `RESP_OKAY);
        end
        axi_write(`CTRL_ADDR, 32'h0, 4'h1, `RESP_OKAY);
        repeat (3) @(posedge aclk);
        check_word("lanes", 20'h0000F, {lane_prng_on, lane_pattern,
            lane_normal});
        axi_write(`LPC_ADDR, 32'h04, 4'h3, `RESP_OKAY);
        axi_write(`LPC_ADDR, 32'h05, 4'h3, `RESP_OKAY);
        send(pack(1, -1, 3, -3), pack(0, -1, 2, -3), 0);
        drain();
        axi_read(`STAT_ADDR, 32'h100, `RESP_OKAY);
        axi_write(`LPC_ADDR, 32'h24, 4'h3, `RESP_OKAY);
        axi_write(`LPC_ADDR, 32'h25, 4'h3, `RESP_OKAY);
        send(pack(1, -1, 3, -3), pack(1, -1, 2, -2), 0);
        for (int k = 2; k <= 10; k++) begin
            cf = (2.0 ** k) / (2.0 ** k + 1.0);
            drain();
            axi_write(`LPC_ADDR, 32'h20 | (k << 1), 4'h3, `RESP_OKAY);
            // A zero sample with the filter off clears both histories.
            send(56'h0, 56'h0, 0);
            axi_write(`LPC_ADDR, 32'h21 | (k << 1), 4'h3, `RESP_OKAY);
            fsend(cf);
            fsend(cf * cf);
        end
        drain();
        axi_write(`LPC_ADDR, 32'h0, 4'h3, `RESP_OKAY);
        hold <= 1'b1;
        fork
            repeat (36) begin
                d = 56'({rnd(), rnd()});
                send(d, d, 0);
            end
            begin
                // Ready is registered, so it falls a few cycles after the
                // level crosses its mark; look once it has surely fallen.
                repeat (64) @(posedge aclk);
                check_word("s_ready", 32'h0, {31'h0, s_ready});
                hold <= 1'b0;
            end
        join
        drain();
        give_verdict();
    end
endmodule : tb_lvds_cfg_top
